// [multi_purpose_pin_pkg.sv]
// Operation
// - sixteen pins, each set by software as input or output
// - two banks of six byte registers, one bit per pin
// - pin interrupts ORed into one request for the uart 0 status
// - timer ownership of pin 0 overrides all pin configuration
// - enable bit per pin; output pins never interrupt
// - interrupts are edge sensed; inversion sets active polarity
// - reading the level register clears pending pin interrupts
// - level register sets driven value of output pins; resets to 0
// - level register read returns the state of input pins
// - tristate bit 1 floats the output; 0 drives the level
// - invert bit 1 inverts the input; resets to 0
// - direction bit 1 is input, 0 output; all reset to input
// - open drain bit makes output open drain; no effect on inputs
// - timer on pin 0 forces it to output, idling high
package multi_purpose_pin_pkg;

   localparam int NUM_PINS = 16;
   localparam int BANK_W = 8;
   localparam int NUM_BANKS = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int EDGE_WARM_CYCLES = 3;

   // -----------------------------------------------
   // register map, byte addresses
   // -----------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_LEVEL = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_TRI = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_INV = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_DIR = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_OD = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_BANK1 = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h40;
   localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h44;

   localparam logic [BANK_W-1:0] RST_INT_EN = 8'h00;
   localparam logic [BANK_W-1:0] RST_LEVEL = 8'h00;
   localparam logic [BANK_W-1:0] RST_TRI = 8'h00;
   localparam logic [BANK_W-1:0] RST_INV = 8'h00;
   localparam logic [BANK_W-1:0] RST_DIR = 8'hFF;
   localparam logic [BANK_W-1:0] RST_OD = 8'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // -----------------------------------------------
   // carriers
   // -----------------------------------------------
   typedef struct packed {
      logic [BANK_W-1:0] int_en;
      logic [BANK_W-1:0] level;
      logic [BANK_W-1:0] tristate;
      logic [BANK_W-1:0] invert;
      logic [BANK_W-1:0] dir;
      logic [BANK_W-1:0] od;
   } pin_bank_t;

   localparam pin_bank_t BANK_RST = '{int_en: RST_INT_EN, level: RST_LEVEL,
      tristate: RST_TRI, invert: RST_INV, dir: RST_DIR, od: RST_OD};

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;

endpackage

// [multi_purpose_pin_edge_sense.sv]
`timescale 1ns/1ps
module multi_purpose_pin_edge_sense #(
   parameter int WIDTH = multi_purpose_pin_pkg::NUM_PINS
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] invert,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o
);
   import multi_purpose_pin_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] prev;
      logic [EDGE_WARM_CYCLES-1:0] warm;
   } edge_state_t;

   edge_state_t s_ff;
   edge_state_t nxt_s;

   // -----------------------------------------------
   // state
   // -----------------------------------------------
   always_comb
   begin
      nxt_s.meta = pin_in;
      nxt_s.sync = s_ff.meta;
      nxt_s.prev = level_o;
      nxt_s.warm = {s_ff.warm[EDGE_WARM_CYCLES-2:0], 1'b1};
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end

   // no edges until the chain holds real samples, else reset fakes one
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      assign level_o[i] = s_ff.sync[i] ^ invert[i];
      assign rise_o[i] = level_o[i] & ~s_ff.prev[i] & s_ff.warm[EDGE_WARM_CYCLES-1];
   end

   inv_path_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n, 2) |-> level_o == ($past(pin_in, 2) ^ invert))
      else $error("input level not synchronised pin xor invert");

endmodule

// [multi_purpose_pin_port.sv]
`timescale 1ns/1ps
module multi_purpose_pin_port
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire multi_purpose_pin_pkg::axil_req_t axi_req,
   output multi_purpose_pin_pkg::axil_rsp_t axi_rsp,
   input wire logic [multi_purpose_pin_pkg::NUM_PINS-1:0] pin_in,
   output logic [multi_purpose_pin_pkg::NUM_PINS-1:0] pin_out,
   output logic [multi_purpose_pin_pkg::NUM_PINS-1:0] pin_oe_n,
   input wire logic timer_route,
   input wire logic timer_out,
   output logic pin_int_req,
   output logic irq
);
   import multi_purpose_pin_pkg::*;

   typedef struct packed {
      pin_bank_t [NUM_BANKS-1:0] bank;
      logic [NUM_PINS-1:0] pending;
      logic [NUM_PINS-1:0] evt_status;
      logic [NUM_PINS-1:0] evt_mask;
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [DATA_W-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic [NUM_PINS-1:0] pin_out;
      logic [NUM_PINS-1:0] pin_oe_n;
      logic irq;
   } port_state_t;

   typedef struct packed {
      logic hit;
      logic bank;
      logic [ADDR_W-1:0] key;
   } addr_dec_t;

   logic [1:0] rst_sync_ff;
   logic rst_core_n;
   port_state_t s_ff;
   port_state_t nxt_s;
   logic [NUM_PINS-1:0] cfg_int_en;
   logic [NUM_PINS-1:0] cfg_level;
   logic [NUM_PINS-1:0] cfg_tri;
   logic [NUM_PINS-1:0] cfg_inv;
   logic [NUM_PINS-1:0] cfg_dir;
   logic [NUM_PINS-1:0] cfg_od;
   logic [NUM_PINS-1:0] route_mask;
   logic [NUM_PINS-1:0] dir_eff;
   logic [NUM_PINS-1:0] in_level;
   logic [NUM_PINS-1:0] in_rise;
   logic [NUM_PINS-1:0] pin_evt;
   logic [NUM_PINS-1:0] drv_out;
   logic [NUM_PINS-1:0] drv_oe_n;
   logic [NUM_PINS-1:0] rd_level;
   logic [NUM_PINS-1:0] plain_mask;
   logic [NUM_PINS-1:0] rel_mask;
   logic [NUM_PINS-1:0] rd_word;
   logic [BANK_W-1:0] rd_lvl_sel;
   pin_bank_t rd_bank;
   addr_dec_t rdec;
   addr_dec_t wdec;
   logic do_write;
   logic ar_take;
   logic clr_pending;
   logic clr_status;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_core_n);

   // -----------------------------------------------
   // reset release
   // -----------------------------------------------
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_ff <= 2'b00;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   assign rst_core_n = rst_sync_ff[1];

   // -----------------------------------------------
   // address decode
   // -----------------------------------------------
   // both banks share one layout; the bank bit is stripped to form the key
   function automatic addr_dec_t decode(input logic [ADDR_W-1:0] a);
      addr_dec_t d;
      logic [ADDR_W-1:0] w;
      w = {a[ADDR_W-1:2], 2'b00};
      d.bank = 1'b0;
      d.key = w;
      d.hit = (w == OFF_EVT_STATUS) || (w == OFF_EVT_MASK);
      if (w < OFF_EVT_STATUS)
      begin
         d.bank = |(w & OFF_BANK1);
         d.key = w & ~OFF_BANK1;
         d.hit = (d.key <= OFF_OD);
      end
      return d;
   endfunction

   assign rdec = decode(axi_req.araddr);
   assign wdec = decode(s_ff.aw_addr);

   // -----------------------------------------------
   // pin configuration view
   // -----------------------------------------------
   for (genvar b = 0; b < NUM_BANKS; b++)
   begin : g_bank
      assign cfg_int_en[b*BANK_W +: BANK_W] = s_ff.bank[b].int_en;
      assign cfg_level[b*BANK_W +: BANK_W] = s_ff.bank[b].level;
      assign cfg_tri[b*BANK_W +: BANK_W] = s_ff.bank[b].tristate;
      assign cfg_inv[b*BANK_W +: BANK_W] = s_ff.bank[b].invert;
      assign cfg_dir[b*BANK_W +: BANK_W] = s_ff.bank[b].dir;
      assign cfg_od[b*BANK_W +: BANK_W] = s_ff.bank[b].od;
   end

   // timer owns pin 0 as an output while routed; the registers keep their values
   assign route_mask = {{(NUM_PINS-1){1'b0}}, timer_route};
   assign dir_eff = cfg_dir & ~route_mask;

   multi_purpose_pin_edge_sense #(
      .WIDTH(NUM_PINS)
   ) u_edge (
      .mclk(mclk),
      .rst_n(rst_core_n),
      .pin_in(pin_in),
      .invert(cfg_inv),
      .level_o(in_level),
      .rise_o(in_rise)
   );

   assign pin_evt = in_rise & cfg_int_en & dir_eff;

   // -----------------------------------------------
   // pin drivers
   // -----------------------------------------------
   for (genvar i = 0; i < NUM_PINS; i++)
   begin : g_pin
      // open drain only ever pulls low; a high level releases the pin
      assign drv_out[i] = route_mask[i] ? timer_out : (~cfg_od[i] & cfg_level[i]);
      assign drv_oe_n[i] = ~route_mask[i] &
         (cfg_dir[i] | cfg_tri[i] | (cfg_od[i] & cfg_level[i]));
      assign rd_level[i] = dir_eff[i] ? in_level[i] :
         (route_mask[i] ? timer_out : cfg_level[i]);
      assign plain_mask[i] = ~route_mask[i] & ~cfg_dir[i] & ~cfg_tri[i] & ~cfg_od[i];
      assign rel_mask[i] = ~route_mask[i] & (cfg_dir[i] | cfg_tri[i] | (cfg_od[i] & cfg_level[i]));
   end

   // -----------------------------------------------
   // read mux
   // -----------------------------------------------
   assign rd_lvl_sel = rd_level[rdec.bank*BANK_W +: BANK_W];

   always_comb
   begin
      rd_word = '0;
      rd_bank = s_ff.bank[rdec.bank];
      case (rdec.key)
         OFF_INT_EN: rd_word[BANK_W-1:0] = rd_bank.int_en;
         OFF_LEVEL: rd_word[BANK_W-1:0] = rd_lvl_sel;
         OFF_TRI: rd_word[BANK_W-1:0] = rd_bank.tristate;
         OFF_INV: rd_word[BANK_W-1:0] = rd_bank.invert;
         OFF_DIR: rd_word[BANK_W-1:0] = rd_bank.dir;
         OFF_OD: rd_word[BANK_W-1:0] = rd_bank.od;
         OFF_EVT_STATUS: rd_word = s_ff.evt_status;
         OFF_EVT_MASK: rd_word = s_ff.evt_mask;
         default: rd_word = '0;
      endcase
   end

   // -----------------------------------------------
   // next state
   // -----------------------------------------------
   always_comb
   begin
      nxt_s = s_ff;
      do_write = s_ff.aw_held && s_ff.w_held && !s_ff.bvalid;
      ar_take = axi_req.arvalid && !s_ff.rvalid;
      clr_pending = 1'b0;
      clr_status = 1'b0;

      // address and data are parked independently, in either order
      if (axi_req.awvalid && !s_ff.aw_held)
      begin
         nxt_s.aw_held = 1'b1;
         nxt_s.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !s_ff.w_held)
      begin
         nxt_s.w_held = 1'b1;
         nxt_s.w_data = axi_req.wdata;
         nxt_s.w_strb = axi_req.wstrb;
      end
      if (s_ff.bvalid && axi_req.bready)
         nxt_s.bvalid = 1'b0;

      if (do_write)
      begin
         nxt_s.aw_held = 1'b0;
         nxt_s.w_held = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = wdec.hit ? RESP_OKAY : RESP_SLVERR;
         if (wdec.hit && s_ff.w_strb[0])
         begin
            case (wdec.key)
               OFF_INT_EN: nxt_s.bank[wdec.bank].int_en = s_ff.w_data[BANK_W-1:0];
               OFF_LEVEL: nxt_s.bank[wdec.bank].level = s_ff.w_data[BANK_W-1:0];
               OFF_TRI: nxt_s.bank[wdec.bank].tristate = s_ff.w_data[BANK_W-1:0];
               OFF_INV: nxt_s.bank[wdec.bank].invert = s_ff.w_data[BANK_W-1:0];
               OFF_DIR: nxt_s.bank[wdec.bank].dir = s_ff.w_data[BANK_W-1:0];
               OFF_OD: nxt_s.bank[wdec.bank].od = s_ff.w_data[BANK_W-1:0];
               OFF_EVT_MASK: nxt_s.evt_mask[BANK_W-1:0] = s_ff.w_data[BANK_W-1:0];
               default: nxt_s.evt_mask = s_ff.evt_mask;
            endcase
         end
         if (wdec.hit && s_ff.w_strb[1] && wdec.key == OFF_EVT_MASK)
            nxt_s.evt_mask[NUM_PINS-1:BANK_W] = s_ff.w_data[NUM_PINS-1:BANK_W];
      end

      if (s_ff.rvalid && axi_req.rready)
         nxt_s.rvalid = 1'b0;
      if (ar_take)
      begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rdata = {{(DATA_W-NUM_PINS){1'b0}}, rd_word};
         nxt_s.rresp = rdec.hit ? RESP_OKAY : RESP_SLVERR;
         clr_pending = rdec.hit && (rdec.key == OFF_LEVEL);
         clr_status = rdec.hit && (rdec.key == OFF_EVT_STATUS);
      end

      // a new edge in the clearing cycle survives the clear
      nxt_s.pending = (s_ff.pending & ~{NUM_PINS{clr_pending}}) | pin_evt;
      nxt_s.evt_status = (s_ff.evt_status & ~{NUM_PINS{clr_status}}) | pin_evt;
      nxt_s.irq = |(nxt_s.evt_status & s_ff.evt_mask);
      nxt_s.pin_out = drv_out;
      nxt_s.pin_oe_n = drv_oe_n;
   end

   always_ff @(posedge mclk or negedge rst_core_n)
   begin
      if (!rst_core_n)
      begin
         s_ff <= '0;
         s_ff.bank <= {NUM_BANKS{BANK_RST}};
         s_ff.pin_oe_n <= '1;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // -----------------------------------------------
   // outputs
   // -----------------------------------------------
   assign axi_rsp.awready = !s_ff.aw_held;
   assign axi_rsp.wready = !s_ff.w_held;
   assign axi_rsp.bvalid = s_ff.bvalid;
   assign axi_rsp.bresp = s_ff.bresp;
   assign axi_rsp.arready = !s_ff.rvalid;
   assign axi_rsp.rvalid = s_ff.rvalid;
   assign axi_rsp.rdata = s_ff.rdata;
   assign axi_rsp.rresp = s_ff.rresp;
   assign pin_out = s_ff.pin_out;
   assign pin_oe_n = s_ff.pin_oe_n;
   assign pin_int_req = |s_ff.pending;
   assign irq = s_ff.irq;

   // -----------------------------------------------
   // checks
   // -----------------------------------------------
   sequence ar_take_s;
      axi_req.arvalid && axi_rsp.arready;
   endsequence

   sequence lvl_read_s;
      ar_take_s ##0 (rdec.hit && rdec.key == OFF_LEVEL);
   endsequence

   reset_config_a: assert property ($rose(rst_core_n) |->
      cfg_dir == '1 && cfg_level == '0 && cfg_tri == '0 && cfg_inv == '0 &&
      cfg_od == '0 && cfg_int_en == '0)
      else $error("pin configuration not at reset values");

   wr_dir_a: assert property (do_write && wdec.hit && wdec.bank &&
      wdec.key == OFF_DIR && s_ff.w_strb[0] |=>
      cfg_dir[NUM_PINS-1:BANK_W] == $past(s_ff.w_data[BANK_W-1:0]))
      else $error("direction write to upper bank lost");

   out_drive_a: assert property (1'b1 |=>
      ((pin_out ^ $past(cfg_level)) & $past(plain_mask)) == '0 &&
      (pin_oe_n & $past(plain_mask)) == '0)
      else $error("output pin not driving its level");

   release_a: assert property (1'b1 |=>
      (~pin_oe_n & $past(rel_mask)) == '0)
      else $error("pin driven while it should be released");

   timer_pin_a: assert property (timer_route |=>
      !pin_oe_n[0] && pin_out[0] == $past(timer_out))
      else $error("pin 0 not following the timer");

   out_no_irq_a: assert property (1'b1 |=>
      (s_ff.pending & ~$past(s_ff.pending) & ~$past(dir_eff & cfg_int_en)) == '0)
      else $error("interrupt from a disabled or output pin");

   edge_irq_a: assert property (pin_evt != '0 |=> pin_int_req &&
      (s_ff.evt_status & $past(pin_evt)) == $past(pin_evt))
      else $error("pin edge did not raise the request");

   level_clear_a: assert property (lvl_read_s ##0 (pin_evt == '0) |=>
      !pin_int_req)
      else $error("level read did not clear the request");

   level_read_a: assert property (lvl_read_s |=>
      axi_rsp.rvalid && axi_rsp.rdata[BANK_W-1:0] == $past(rd_lvl_sel))
      else $error("level read returned wrong pin state");

endmodule

// [multi_purpose_pin_pin_model.sv]
`timescale 1ns/1ps
module multi_purpose_pin_pin_model
(
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe_n,
   input wire logic [15:0] ext_val,
   input wire logic [15:0] ext_en,
   output logic [15:0] pin_in
);
   // every line has a pull-up, so a released pin, open drain at level 1 included, reads high
   // both sides driving at once shows as unknown rather than a lucky value
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         if (!pin_oe_n[i])
            pin_in[i] = ext_en[i] ? 1'bx : pin_out[i];
         else
            pin_in[i] = ext_en[i] ? ext_val[i] : 1'h1;
      end
   end
endmodule

// [multipurpose_io_port_test.sv]
`timescale 1ns/1ps
module multipurpose_io_port_test;
   import multi_purpose_pin_pkg::*;
   logic mclk, rst_n, timer_route, timer_out, pin_int_req, irq;
   axil_req_t req;
   axil_rsp_t rsp;
   logic [15:0] pin_in, pin_out, pin_oe_n, ext_val, ext_en, d, t, o, l, v, iv, x;
   logic [31:0] rd, e;
   logic [1:0] rs;
   int err_total = 0;
   int checks = 0;
   logic [7:0] offs [6] = '{OFF_INT_EN, OFF_LEVEL, OFF_TRI, OFF_INV, OFF_DIR, OFF_OD};
   logic [7:0] rsts [6] = '{RST_INT_EN, RST_LEVEL, RST_TRI, RST_INV, RST_DIR, RST_OD};

   multi_purpose_pin_port multi_purpose_pin_port_inst (.mclk(mclk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .timer_route(timer_route),
      .timer_out(timer_out), .pin_int_req(pin_int_req), .irq(irq));
   multi_purpose_pin_pin_model multi_purpose_pin_pin_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

   task automatic wrap_up();
      if (err_total == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hang(input int n);
      if (n >= 200)
      begin
         err_total++;
         wrap_up();
      end
   endtask

   // ----------------------------------------
   // bus master
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      int n = 0;
      @(posedge mclk);
      req.awvalid <= 1'h1;
      req.awaddr <= a;
      req.wvalid <= 1'h1;
      req.wdata <= dat;
      req.wstrb <= 4'hF;
      req.bready <= 1'h1;
      do
      begin
         @(posedge mclk);
         n++;
         if (req.awvalid && rsp.awready)
            req.awvalid <= 1'h0;
         if (req.wvalid && rsp.wready)
            req.wvalid <= 1'h0;
      end
      while (!rsp.bvalid && n < 200);
      rs = rsp.bresp;
      req.bready <= 1'h0;
      hang(rsp.bvalid ? 0 : 200);
   endtask

   task automatic rdr(input logic [7:0] a);
      int n = 0;
      @(posedge mclk);
      req.arvalid <= 1'h1;
      req.araddr <= a;
      req.rready <= 1'h1;
      do
      begin
         @(posedge mclk);
         n++;
         if (req.arvalid && rsp.arready)
            req.arvalid <= 1'h0;
      end
      while (!rsp.rvalid && n < 200);
      rd = rsp.rdata;
      rs = rsp.rresp;
      req.rready <= 1'h0;
      hang(rsp.rvalid ? 0 : 200);
   endtask

   // one bit per pin, low byte in bank 0 and high byte in bank 1
   task automatic wrb(input logic [7:0] a, input logic [15:0] val);
      wr(a, {24'h0, val[7:0]});
      wr(a + OFF_BANK1, {24'h0, val[15:8]});
   endtask

   task automatic rdb(input logic [7:0] a, output logic [15:0] val);
      rdr(a);
      val[7:0] = rd[7:0];
      rdr(a + OFF_BANK1);
      val[15:8] = rd[7:0];
   endtask

   // expected {oe_n, out}; out only counts where the pin is driven
   function automatic logic [31:0] drv(input logic [15:0] d, t, o, l);
      logic [15:0] oe;
      oe = d | t | (o & l);
      return {oe, ~o & l & ~oe};
   endfunction

   initial
   begin
      mclk = 1'h0;
      forever #12.5 mclk = ~mclk;
   end

   initial
   begin
      rst_n = 1'h0;
      req = '0;
      timer_route = 1'h0;
      timer_out = 1'h1;
      ext_val = 16'h0000;
      ext_en = 16'h0000;
      void'($urandom(32'hC99F));
      repeat (8) @(posedge mclk);
      chk(pin_oe_n, 32'hFFFF);
      chk(pin_out, 32'h0000);
      rst_n <= 1'h1;
      repeat (3) @(posedge mclk);
      for (int b = 0; b < 2; b++)
         for (int i = 0; i < 6; i++)
         begin
            rdr(offs[i] + (b ? OFF_BANK1 : 8'h00));
            // released inputs read the pull-up level
            chk(rd, (i != 1) ? {24'h0, rsts[i]} : 32'h0000_00FF);
            chk(rs, RESP_OKAY);
         end
      rdr(8'h3C);
      chk({rs, rd[29:0]}, {RESP_SLVERR, 30'h0});
      wr(8'h3C, 32'h0000_00FF);
      chk(rs, RESP_SLVERR);
      wrb(OFF_DIR, 16'h0000);
      repeat (3) @(posedge mclk);
      chk({pin_oe_n, pin_out}, 32'h0);
      for (int k = 0; k < 10; k++)
      begin
         d = 16'($urandom);
         t = 16'($urandom);
         o = 16'($urandom);
         l = 16'($urandom);
         v = 16'($urandom);
         iv = 16'($urandom);
         if (k == 0)
         begin
            d = 16'h0000;
            t = 16'h0000;
         end
         if (k == 1)
            d = 16'hFFFF;
         ext_en <= ext_en & d;
         wrb(OFF_INV, iv);
         wrb(OFF_LEVEL, l);
         wrb(OFF_TRI, t);
         wrb(OFF_OD, o);
         wrb(OFF_DIR, d);
         ext_en <= d;
         ext_val <= v;
         repeat (5) @(posedge mclk);
         e = drv(d, t, o, l);
         chk({pin_oe_n, pin_out & ~e[31:16]}, e);
         rdb(OFF_LEVEL, x);
         chk(x, (d & (v ^ iv)) | (~d & l));
      end
      // ----------------------------------------
      // edge interrupts
      // ----------------------------------------
      wrb(OFF_DIR, 16'hFFFF);
      wrb(OFF_INV, 16'h0000);
      ext_en <= 16'hFFFF;
      ext_val <= 16'h0000;
      repeat (6) @(posedge mclk);
      rdb(OFF_LEVEL, x);
      rdr(OFF_EVT_STATUS);
      wrb(OFF_INT_EN, 16'h8001);
      ext_val <= 16'h8000;
      repeat (6) @(posedge mclk);
      chk({pin_int_req, irq}, 32'h2);
      rdb(OFF_LEVEL, x);
      repeat (2) @(posedge mclk);
      chk(pin_int_req, 32'h0);
      rdr(OFF_EVT_STATUS);
      chk(rd, 32'h8000);
      wr(OFF_EVT_MASK, 32'h0001);
      chk(rs, RESP_OKAY);
      wrb(OFF_INV, 16'h0001);
      repeat (6) @(posedge mclk);
      chk({pin_int_req, irq}, 32'h3);
      rdr(OFF_EVT_STATUS);
      chk(rd, 32'h0001);
      repeat (2) @(posedge mclk);
      chk(irq, 32'h0);
      rdb(OFF_LEVEL, x);
      ext_val <= 16'h8001;
      repeat (6) @(posedge mclk);
      chk(pin_int_req, 32'h0);
      ext_val <= 16'h8000;
      repeat (6) @(posedge mclk);
      chk({pin_int_req, irq}, 32'h3);
      wrb(OFF_INV, 16'h0000);
      ext_en <= 16'hFFFE;
      wrb(OFF_DIR, 16'hFFFE);
      wrb(OFF_LEVEL, 16'h0000);
      repeat (6) @(posedge mclk);
      rdb(OFF_LEVEL, x);
      rdr(OFF_EVT_STATUS);
      wrb(OFF_LEVEL, 16'h0001);
      repeat (6) @(posedge mclk);
      chk({pin_int_req, irq}, 32'h0);
      // ----------------------------------------
      // timer on pin 0
      // ----------------------------------------
      wrb(OFF_DIR, 16'hFFFF);
      wrb(OFF_TRI, 16'hFFFF);
      for (int tv = 0; tv < 2; tv++)
      begin
         timer_route <= 1'h1;
         timer_out <= tv[0];
         repeat (3) @(posedge mclk);
         chk({pin_oe_n[0], pin_out[0]}, {31'h0, tv[0]});
      end
      timer_route <= 1'h0;
      repeat (3) @(posedge mclk);
      chk(pin_oe_n[0], 32'h1);
      wrap_up();
   end
endmodule
